// *** hdl/ssaes_pkg.sv ***
package ssaes_pkg;
   // Field widths
   localparam int SPD_W = 16;
   localparam int DEV_W = 17;
   localparam int HYS_W = 9;
   localparam int TMR_W = 10;
   localparam int FRQ_W = 16;
   localparam int ATT_W = 5;
   localparam int FLT_W = 13;
   localparam int GAIN_W = 11;
   localparam int ITG_W = 14;
   localparam int SEL_W = 3;
   localparam int CNT_W = 32;
   // Motor indices
   localparam logic [1:0] MOTOR_ONE = 2'h0;
   // Notch attenuation: zero dB disables
   localparam logic [ATT_W-1:0] ATT_OFF = 5'h00;
   localparam logic [ATT_W-1:0] ATT_MAX = 5'h14;
   // Jog set defaults and ranges (ms, gain in 0.1)
   localparam logic [FLT_W-1:0] JOG_CMD_FLT_DEF = 13'h0014;
   localparam logic [FLT_W-1:0] JOG_DET_FLT_DEF = 13'h0005;
   localparam logic [FLT_W-1:0] JOG_OUT_FLT_DEF = 13'h0002;
   localparam logic [FLT_W-1:0] OUT_FLT_MAX = 13'h0064;
   localparam logic [FLT_W-1:0] CMD_FLT_MAX = 13'h1388;
   localparam logic [FLT_W-1:0] DET_FLT_MAX = 13'h0064;
   localparam logic [GAIN_W-1:0] GAIN_DEF = 11'h064;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 11'h001;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 11'h7D0;
   localparam logic [ITG_W-1:0] ITG_DEF = 14'h0064;
   localparam logic [ITG_W-1:0] ITG_OFF_CODE = 14'h03E7;
   localparam logic [ITG_W-1:0] ITG_MIN = 14'h0001;
   localparam logic [ITG_W-1:0] ITG_MAX = 14'h270F;
   // Agreement settings (0.1 % and 0.01 s)
   localparam logic [HYS_W-1:0] HYS_DEF = 9'h064;
   localparam logic [HYS_W-1:0] HYS_MAX = 9'h1F4;
   localparam logic [TMR_W-1:0] TMR_DEF = 10'h032;
   localparam logic [TMR_W-1:0] TMR_MAX = 10'h3E8;
   // Error processing selections
   localparam logic [SEL_W-1:0] PROC_DEF = 3'h2;
   localparam logic [SEL_W-1:0] PROC_MAX = 3'h5;
   localparam logic [SEL_W-1:0] PROC_SCALE_MIN = 3'h3;
   // Timing
   localparam int CLK_HZ = 100000000;
   localparam real TMR_UNIT_S = 0.01;
   localparam int TMR_UNIT_CYC = int'(TMR_UNIT_S * CLK_HZ);
endpackage

// *** hdl/ssaes_width.sv ***
`timescale 1ns/1ps
module ssaes_width
   import ssaes_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Settings
   input wire logic [SEL_W-1:0] err_proc,
   input wire logic [HYS_W-1:0] hyst,
   input wire logic [FRQ_W-1:0] cmd_freq,
   input wire logic [FRQ_W-1:0] base_freq,
   // Detection width
   output logic [DEV_W-1:0] width
);
   logic [DEV_W-1:0] width_r;
   logic [DEV_W-1:0] width_nxt;
   logic [HYS_W+FRQ_W-1:0] prod;
   logic [HYS_W+FRQ_W-1:0] quot;

   always_comb begin
      prod = hyst * cmd_freq;
      quot = (base_freq == 16'h0000) ? prod : prod / base_freq;
      width_nxt = DEV_W'(hyst);
      if (err_proc >= PROC_SCALE_MIN && cmd_freq > base_freq) begin
         width_nxt = (quot > 25'h001FFFF) ? 17'h1FFFF : quot[DEV_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         width_r <= DEV_W'(HYS_DEF);
      end else begin
         width_r <= width_nxt;
      end
   end

   assign width = width_r;
endmodule

// *** hdl/ssaes_top.sv ***
`timescale 1ns/1ps
module ssaes_top
   import ssaes_pkg::*;
#(
   parameter int TICK_CYCLES = TMR_UNIT_CYC
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Motor selection
   input wire logic MOTOR_TWO_SELECT_USED,
   input wire logic MOTOR_THREE_SELECT_USED,
   input wire logic MOTOR_FOUR_SELECT_USED,
   input wire logic [2:0] MOTOR_SWITCH_PARAM,
   input wire logic [3:0][ATT_W-1:0] NOTCH_ATTEN,
   // Regulator parameter sets
   input wire logic JOG_ACTIVE,
   input wire logic [FLT_W-1:0] NORM_CMD_FLT,
   input wire logic [FLT_W-1:0] NORM_DET_FLT,
   input wire logic [GAIN_W-1:0] NORM_GAIN,
   input wire logic [ITG_W-1:0] NORM_INTEG,
   input wire logic [FLT_W-1:0] NORM_OUT_FLT,
   input wire logic [FLT_W-1:0] JOG_CMD_FLT,
   input wire logic [FLT_W-1:0] JOG_DET_FLT,
   input wire logic [GAIN_W-1:0] JOG_GAIN,
   input wire logic [ITG_W-1:0] JOG_INTEG,
   input wire logic [FLT_W-1:0] JOG_OUT_FLT,
   // Supervision settings
   input wire logic [HYS_W-1:0] HYST_WIDTH,
   input wire logic [TMR_W-1:0] DETECT_TIME,
   input wire logic [SEL_W-1:0] ERR_PROC,
   input wire logic [FRQ_W-1:0] CMD_FREQ,
   input wire logic [FRQ_W-1:0] BASE_FREQ,
   // Speeds
   input wire logic signed [SPD_W-1:0] REF_SPEED,
   input wire logic signed [SPD_W-1:0] DET_SPEED,
   input wire logic OVERLOAD_LIMIT,
   input wire logic TRIP_CLEAR,
   // Notch routing
   output logic [3:0][1:0] NOTCH_MOTOR,
   output logic [3:0] NOTCH_EN,
   // Active regulator set
   output logic [FLT_W-1:0] ACT_CMD_FLT,
   output logic [FLT_W-1:0] ACT_DET_FLT,
   output logic [GAIN_W-1:0] ACT_GAIN,
   output logic [ITG_W-1:0] ACT_INTEG,
   output logic ACT_P_ONLY,
   output logic [FLT_W-1:0] ACT_OUT_FLT,
   // Supervision
   output logic SPEED_MATCH_FLAG,
   output logic SPEED_FAULT_FLAG,
   output logic SPEED_FAULT_TRIP,
   output logic DRIVE_COAST
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] g);
      clamp_gain = (g < GAIN_MIN) ? GAIN_MIN : (g > GAIN_MAX) ? GAIN_MAX : g;
   endfunction

   function automatic logic [FLT_W-1:0] clamp_flt(input logic [FLT_W-1:0] f,
                                                 input logic [FLT_W-1:0] mx);
      clamp_flt = (f > mx) ? mx : f;
   endfunction

   function automatic logic exempt_sel(input logic [SEL_W-1:0] s);
      exempt_sel = (s != 3'h2) && (s != 3'h5);
   endfunction

   function automatic logic stop_sel(input logic [SEL_W-1:0] s);
      stop_sel = (s != 3'h0) && (s != 3'h3);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Notch routing
   logic [3:0][1:0] notch_motor_r;
   logic [3:0][1:0] notch_motor_nxt;
   logic [3:0] notch_en_r;
   logic [3:0] notch_en_nxt;
   logic all_to_one;

   always_comb begin
      all_to_one = !MOTOR_TWO_SELECT_USED && !MOTOR_THREE_SELECT_USED &&
                   !MOTOR_FOUR_SELECT_USED && (MOTOR_SWITCH_PARAM == 3'h7);
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_notch
         always_comb begin
            notch_motor_nxt[gi] = all_to_one ? MOTOR_ONE : 2'(gi);
            notch_en_nxt[gi] = (NOTCH_ATTEN[gi] != ATT_OFF);
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         notch_motor_r <= '0;
         notch_en_r <= '0;
      end else begin
         notch_motor_r <= notch_motor_nxt;
         notch_en_r <= notch_en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Regulator parameter set
   logic [FLT_W-1:0] cmd_flt_r, cmd_flt_nxt;
   logic [FLT_W-1:0] det_flt_r, det_flt_nxt;
   logic [FLT_W-1:0] out_flt_r, out_flt_nxt;
   logic [GAIN_W-1:0] gain_r, gain_nxt;
   logic [ITG_W-1:0] integ_r, integ_nxt;
   logic p_only_r, p_only_nxt;
   logic [ITG_W-1:0] integ_sel;

   always_comb begin
      integ_sel = JOG_ACTIVE ? JOG_INTEG : NORM_INTEG;
      if (JOG_ACTIVE) begin
         cmd_flt_nxt = clamp_flt(JOG_CMD_FLT, CMD_FLT_MAX);
         det_flt_nxt = clamp_flt(JOG_DET_FLT, DET_FLT_MAX);
         out_flt_nxt = clamp_flt(JOG_OUT_FLT, OUT_FLT_MAX);
         gain_nxt = clamp_gain(JOG_GAIN);
      end else begin
         cmd_flt_nxt = clamp_flt(NORM_CMD_FLT, CMD_FLT_MAX);
         det_flt_nxt = clamp_flt(NORM_DET_FLT, DET_FLT_MAX);
         out_flt_nxt = clamp_flt(NORM_OUT_FLT, OUT_FLT_MAX);
         gain_nxt = clamp_gain(NORM_GAIN);
      end
      p_only_nxt = (integ_sel == ITG_OFF_CODE);
      if (p_only_nxt) begin
         integ_nxt = '0;
      end else if (integ_sel < ITG_MIN) begin
         integ_nxt = ITG_MIN;
      end else if (integ_sel > ITG_MAX) begin
         integ_nxt = ITG_MAX;
      end else begin
         integ_nxt = integ_sel;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cmd_flt_r <= JOG_CMD_FLT_DEF;
         det_flt_r <= JOG_DET_FLT_DEF;
         out_flt_r <= JOG_OUT_FLT_DEF;
         gain_r <= GAIN_DEF;
         integ_r <= ITG_DEF;
         p_only_r <= 1'b0;
      end else begin
         cmd_flt_r <= cmd_flt_nxt;
         det_flt_r <= det_flt_nxt;
         out_flt_r <= out_flt_nxt;
         gain_r <= gain_nxt;
         integ_r <= integ_nxt;
         p_only_r <= p_only_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings capture
   logic [SEL_W-1:0] proc_r, proc_nxt;
   logic [HYS_W-1:0] hyst_r, hyst_nxt;
   logic [TMR_W-1:0] tmr_r, tmr_nxt;
   logic [DEV_W-1:0] width;

   always_comb begin
      proc_nxt = (ERR_PROC > PROC_MAX) ? proc_r : ERR_PROC;
      hyst_nxt = (HYST_WIDTH > HYS_MAX) ? HYS_MAX : HYST_WIDTH;
      tmr_nxt = (DETECT_TIME > TMR_MAX) ? TMR_MAX : DETECT_TIME;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         proc_r <= PROC_DEF;
         hyst_r <= HYS_DEF;
         tmr_r <= TMR_DEF;
      end else begin
         proc_r <= proc_nxt;
         hyst_r <= hyst_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   ssaes_width u_width (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .err_proc(proc_r),
      .hyst(hyst_r),
      .cmd_freq(CMD_FREQ),
      .base_freq(BASE_FREQ),
      .width(width)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Deviation and persistence timers
   logic signed [DEV_W-1:0] diff;
   logic [DEV_W-1:0] dev;
   logic outside, exempt, fault_cond;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] match_cnt_r, match_cnt_nxt;
   logic [CNT_W-1:0] fault_cnt_r, fault_cnt_nxt;
   logic match_r, match_nxt;
   logic fault_r, fault_nxt;
   logic trip_r, trip_nxt;
   logic coast_r, coast_nxt;

   always_comb begin
      diff = DEV_W'(REF_SPEED) - DEV_W'(DET_SPEED);
      dev = diff[DEV_W-1] ? DEV_W'(-diff) : DEV_W'(diff);
      outside = dev > width;
      exempt = exempt_sel(proc_r) && OVERLOAD_LIMIT && (DET_SPEED < REF_SPEED);
      fault_cond = outside && !exempt;
      limit = CNT_W'(tmr_r) * CNT_W'(TICK_CYCLES);
      match_cnt_nxt = outside ? match_cnt_r : '0;
      if (outside && match_cnt_r < limit) begin
         match_cnt_nxt = match_cnt_r + 32'h00000001;
      end
      fault_cnt_nxt = fault_cond ? fault_cnt_r : '0;
      if (fault_cond && fault_cnt_r < limit) begin
         fault_cnt_nxt = fault_cnt_r + 32'h00000001;
      end
      match_nxt = !outside || (match_cnt_r < limit);
      fault_nxt = fault_cond && (fault_cnt_r >= limit);
      trip_nxt = trip_r && !TRIP_CLEAR;
      if (fault_nxt && stop_sel(proc_r)) begin
         trip_nxt = 1'b1;
      end
      coast_nxt = trip_nxt;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         match_cnt_r <= '0;
         fault_cnt_r <= '0;
         match_r <= 1'b0;
         fault_r <= 1'b0;
         trip_r <= 1'b0;
         coast_r <= 1'b0;
      end else begin
         match_cnt_r <= match_cnt_nxt;
         fault_cnt_r <= fault_cnt_nxt;
         match_r <= match_nxt;
         fault_r <= fault_nxt;
         trip_r <= trip_nxt;
         coast_r <= coast_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      NOTCH_MOTOR = notch_motor_r;
      NOTCH_EN = notch_en_r;
      ACT_CMD_FLT = cmd_flt_r;
      ACT_DET_FLT = det_flt_r;
      ACT_GAIN = gain_r;
      ACT_INTEG = integ_r;
      ACT_P_ONLY = p_only_r;
      ACT_OUT_FLT = out_flt_r;
      SPEED_MATCH_FLAG = match_r;
      SPEED_FAULT_FLAG = fault_r;
      SPEED_FAULT_TRIP = trip_r;
      DRIVE_COAST = coast_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_notch_all_one: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      all_to_one |=> (notch_motor_r == '0))
      else $error("notch not routed to motor one");
   a_notch_disable: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (NOTCH_ATTEN[0] == ATT_OFF) |=> !notch_en_r[0])
      else $error("zero dB notch enabled");
   a_jog_gain_sel: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (JOG_ACTIVE && JOG_GAIN >= GAIN_MIN && JOG_GAIN <= GAIN_MAX) |=> (gain_r == $past(JOG_GAIN)))
      else $error("jog gain not applied");
   a_p_only_code: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (JOG_ACTIVE && JOG_INTEG == ITG_OFF_CODE) |=> (p_only_r && integ_r == '0))
      else $error("integral not disabled");
   a_gain_range: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      gain_r >= GAIN_MIN && gain_r <= GAIN_MAX)
      else $error("gain out of range");
   a_out_flt_range: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      out_flt_r <= OUT_FLT_MAX)
      else $error("output filter out of range");
   a_match_inside: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      !outside |=> match_r)
      else $error("match flag low inside width");
   a_match_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (match_r && $fell(match_nxt)) |-> (outside && match_cnt_r >= limit))
      else $error("match flag dropped early");
   a_fault_timed: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      $rose(fault_r) |-> $past(fault_cnt_r >= limit))
      else $error("fault before detection time");
   a_exempt_none: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (exempt_sel(proc_r) && OVERLOAD_LIMIT && DET_SPEED < REF_SPEED) |=> !fault_r)
      else $error("fault raised while exempt");
   a_continue_run: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (!trip_r && !stop_sel(proc_r)) |=> !trip_r)
      else $error("trip in continue mode");
   a_trip_coast: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (fault_nxt && stop_sel(proc_r)) |=> (trip_r && coast_r))
      else $error("stop mode did not trip");
   a_proc_default: assert property (@(posedge SYS_CLK)
      SYS_RST |=> (proc_r == PROC_DEF))
      else $error("bad error processing default");
endmodule

// *** dv/ssaes_motor.sv ***
`timescale 1ns/1ps
module ssaes_motor
   import ssaes_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Speed command, lag and overload from bench
   input wire logic signed [SPD_W-1:0] ref_spd,
   input wire logic signed [SPD_W-1:0] lag,
   input wire logic ovl_cmd,
   // Power stage removed
   input wire logic coast,
   // Speed feedback
   output logic signed [SPD_W-1:0] det_spd,
   output logic ovl
);
   logic signed [SPD_W-1:0] det_r;
   logic signed [SPD_W-1:0] det_nxt;
   ////////////////////////////////////////////////////////////////
   // Follows command with lag; coasting decays slowly
   always_comb begin
      if (coast) begin
         det_nxt = det_r - (det_r >>> 3);
      end else begin
         det_nxt = ref_spd - lag;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         det_r <= '0;
      end else begin
         det_r <= det_nxt;
      end
   end
   assign det_spd = det_r;
   assign ovl = ovl_cmd;
endmodule

// *** dv/speed_agreement_error_supervisor_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module speed_agreement_error_supervisor_tb
   import ssaes_pkg::*;
;
   logic clk, rst, m2, m3, m4, jog, ovl, ovl_cmd, tclr, coast;
   logic [2:0] sw;
   logic [3:0][ATT_W-1:0] att;
   logic [FLT_W-1:0] ncf, ndf, nof, jcf, jdf, jof, a_cf, a_df, a_of;
   logic [GAIN_W-1:0] ng, jg, a_g;
   logic [ITG_W-1:0] ni, ji, a_i, sel_i;
   logic [HYS_W-1:0] hyst;
   logic [TMR_W-1:0] dtm;
   logic [SEL_W-1:0] proc;
   logic [FRQ_W-1:0] cfrq, bfrq;
   logic signed [SPD_W-1:0] ref_spd, det_spd, lag;
   logic [3:0][1:0] n_mot, mot_e;
   logic [3:0] n_en, en_e;
   logic a_p, match, fault, trip;
   int error_cnt = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h00015BD3;
   int plist[7] = '{7, 0, 1, 2, 3, 4, 5};
   ////////////////////////////////////////////////////////////////
   // Design and motor
   ssaes_top #(.TICK_CYCLES(2)) i_ssaes_top (.SYS_CLK(clk), .SYS_RST(rst),
      .MOTOR_TWO_SELECT_USED(m2), .MOTOR_THREE_SELECT_USED(m3),
      .MOTOR_FOUR_SELECT_USED(m4), .MOTOR_SWITCH_PARAM(sw), .NOTCH_ATTEN(att),
      .JOG_ACTIVE(jog), .NORM_CMD_FLT(ncf), .NORM_DET_FLT(ndf), .NORM_GAIN(ng),
      .NORM_INTEG(ni), .NORM_OUT_FLT(nof), .JOG_CMD_FLT(jcf), .JOG_DET_FLT(jdf),
      .JOG_GAIN(jg), .JOG_INTEG(ji), .JOG_OUT_FLT(jof), .HYST_WIDTH(hyst),
      .DETECT_TIME(dtm), .ERR_PROC(proc), .CMD_FREQ(cfrq), .BASE_FREQ(bfrq),
      .REF_SPEED(ref_spd), .DET_SPEED(det_spd), .OVERLOAD_LIMIT(ovl),
      .TRIP_CLEAR(tclr), .NOTCH_MOTOR(n_mot), .NOTCH_EN(n_en), .ACT_CMD_FLT(a_cf),
      .ACT_DET_FLT(a_df), .ACT_GAIN(a_g), .ACT_INTEG(a_i), .ACT_P_ONLY(a_p),
      .ACT_OUT_FLT(a_of), .SPEED_MATCH_FLAG(match), .SPEED_FAULT_FLAG(fault),
      .SPEED_FAULT_TRIP(trip), .DRIVE_COAST(coast));
   ssaes_motor i_ssaes_motor (.clk(clk), .rst(rst), .ref_spd(ref_spd), .lag(lag),
      .ovl_cmd(ovl_cmd), .coast(coast), .det_spd(det_spd), .ovl(ovl));
   ////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One supervision case: setting p, width scaling, overload lag
   task automatic sup(int p, bit scale, bit ov);
      int ep;
      bit out_e, f_e, t_e;
      ep = (p > 5) ? 2 : p;
      out_e = 150 > ((scale && ep >= 3) ? 200 : 100);
      f_e = out_e && !(ov && ep inside {0, 1, 3, 4});
      t_e = f_e && (ep inside {1, 2, 4, 5});
      proc = SEL_W'(p);
      cfrq = scale ? 16'h07D0 : 16'h01F4;
      lag = '0;
      ovl_cmd = 1'b0;
      tick(5);
      `CHK("match_in", 1'b1, match)
      lag = 16'sh0096;
      ovl_cmd = ov;
      tick(2);
      lag = '0;
      tick(1);
      lag = 16'sh0096;
      tick(2);
      `CHK("fault_short", 1'b0, fault)
      `CHK("match_short", 1'b1, match)
      tick(6);
      `CHK("match_out", !out_e, match)
      `CHK("fault", f_e, fault)
      `CHK("trip", t_e, trip)
      `CHK("coast", t_e, coast)
      ref_spd = '0;
      lag = '0;
      ovl_cmd = 1'b0;
      tick(60);
      tclr = 1'b1;
      tick(2);
      tclr = 1'b0;
      `CHK("trip_clr", 1'b0, trip)
      ref_spd = 16'sh03E8;
      tick(3);
   endtask
   ////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #1000000;
      error_cnt++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      {m2, m3, m4, sw, jog, ovl_cmd, tclr} = '0;
      att = '0;
      {ncf, ndf, nof, jcf, jdf, jof} = '0;
      {ng, jg} = {GAIN_DEF, GAIN_DEF};
      {ni, ji} = {ITG_DEF, ITG_DEF};
      hyst = HYS_DEF;
      dtm = 10'h001;
      proc = 3'h7;
      cfrq = 16'h01F4;
      bfrq = 16'h03E8;
      ref_spd = 16'sh03E8;
      lag = '0;
      tick(3);
      `CHK("rst_cmd", JOG_CMD_FLT_DEF, a_cf)
      `CHK("rst_det", JOG_DET_FLT_DEF, a_df)
      `CHK("rst_out", JOG_OUT_FLT_DEF, a_of)
      `CHK("rst_gain", GAIN_DEF, a_g)
      `CHK("rst_fault", 1'b0, fault)
      rst = 1'b0;
      for (int i = 0; i < 40; i++) begin
         {m2, m3, m4, sw} = (i % 4 == 0) ? 6'h07 : 6'(rnd());
         for (int n = 0; n < 4; n++) begin
            att[n] = ATT_W'(rnd() % 21);
            mot_e[n] = (!m2 && !m3 && !m4 && sw == 3'h7) ? MOTOR_ONE : 2'(n);
            en_e[n] = att[n] != ATT_OFF;
         end
         jog = 1'(rnd() % 2);
         ncf = FLT_W'(rnd() % 5001);
         jcf = FLT_W'(rnd() % 5001);
         {ndf, jdf, nof, jof} = {FLT_W'(rnd() % 101), FLT_W'(rnd() % 101),
            FLT_W'(rnd() % 101), FLT_W'(rnd() % 101)};
         ng = (i % 7 == 1) ? '0 : GAIN_W'(rnd() % 2000 + 1);
         jg = (i % 5 == 0) ? GAIN_MAX : GAIN_W'(rnd() % 2000 + 1);
         ni = ITG_W'(rnd() % 9999 + 1);
         ji = (i % 3 == 0) ? ITG_OFF_CODE : ITG_W'(rnd() % 9999 + 1);
         sel_i = jog ? ji : ni;
         tick(1);
         `CHK("notch_mot", mot_e, n_mot)
         `CHK("notch_en", en_e, n_en)
         `CHK("cmd_flt", jog ? jcf : ncf, a_cf)
         `CHK("det_flt", jog ? jdf : ndf, a_df)
         `CHK("out_flt", jog ? jof : nof, a_of)
         `CHK("gain", jog ? jg : ((ng < GAIN_MIN) ? GAIN_MIN : ng), a_g)
         `CHK("p_only", sel_i == ITG_OFF_CODE, a_p)
         `CHK("integ", (sel_i == ITG_OFF_CODE) ? '0 : sel_i, a_i)
      end
      foreach (plist[k]) begin
         sup(plist[k], 1'b0, 1'b0);
         sup(plist[k], 1'b1, 1'b0);
         sup(plist[k], 1'b0, 1'b1);
      end
      finish_test();
   end
endmodule
